/* verilog/timer_pkg.sv */
// Constants, field layout and source map of the seven-channel timer unit
// ****************************************************************************
// Overview of operation
// - Capture/compare flag sets one cycle after the counter equals the compare value; prescaled, on the tick that reaches it.
// - Match output and compare request follow one cycle after the flag, two cycles after an unprescaled counter hits the value.
// - Capture copies the counter, flag follows, request at most three cycles after input.
// - Wrap flag sets on 0xFFFF to 0x0000; its request follows one cycle later.
// - In phase mode a downward wrap from 0x0000 to 0xFFFF also sets the wrap flag.
// - 29 sources; compare and capture sources may start transfers, wrap sources never.
// - Dedicated compare sources come in pairs sharing one request line.
// - Fixed priority: channel 1 first, table order inside, channel 7 wrap last.
// - Channel 1 has four general, two dedicated pairs, wrap; channels 2-5 two, one pair.
// - Channels 6 and 7 have two general registers and wrap only.
// - Counter write meeting a compare-match clear: the clear wins, write lost.
// - Counter write meeting a capture clear: the clear wins.
// - Counter write meeting an increment: written value kept, increment dropped.
// - Counter write meeting a wrap still sets the wrap flag.
// - Byte write meeting an increment in the final phase: unwritten byte increments.
// - Reading a capture register as it captures returns the old value.
// - Writing a compare register in the match cycle suppresses that match.
// - A write to a synchronized counter loads all 16 bits into every synchronized one.
// - With the system clock, matches repeat every compare value plus one cycles.
// - Prescaled, matches repeat every ratio times value; value zero never matches.
// - With the system clock or in phase mode, rewriting a compare register alone never makes a match.
// ****************************************************************************
package timer_pkg;
  localparam int NCH  = 7;
  localparam int NVEC = 29;
  localparam int AW   = 12;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Register index inside a channel window (byte address is four times it)
  localparam logic [3:0] IX_CNT  = 4'h0;
  localparam logic [3:0] IX_CTRL = 4'h1;
  localparam logic [3:0] IX_STAT = 4'h2;
  localparam logic [3:0] IX_IEN  = 4'h3;
  localparam logic [3:0] IX_GR   = 4'h4;
  localparam logic [3:0] IX_DR   = 4'h8;
  localparam logic [3:0] IX_SYNC = 4'h0;
  localparam logic [3:0] IX_ARB  = 4'h1;
  // Field positions
  localparam int CF_RUN = 0;
  localparam int CF_PS  = 1;
  localparam int CF_CLR = 4;
  localparam int CF_CAP = 6;
  localparam int CF_PH  = 8;
  localparam int ST_DR  = 4;
  localparam int ST_WR  = 8;
  localparam int IE_DTC = 16;
  // Delays in cycles of the 50 ns clock
  localparam int CLK_NS       = 50;
  localparam int FLAG_DLY_NS  = 50;
  localparam int FLAG_DLY_CYC = (FLAG_DLY_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {CLR_NONE, CLR_GR1, CLR_GR2, CLR_CAP} clr_t;

  function automatic int n_gr(int c);
    return (c == 1) ? 4 : 2;
  endfunction : n_gr

  function automatic int n_dr(int c);
    return (c == 1) ? 4 : ((c <= 5) ? 2 : 0);
  endfunction : n_dr

  // First request line of a channel in priority order
  function automatic int vec_base(int c);
    return (c == 1) ? 0 : ((c <= 6) ? 7 + 4 * (c - 2) : 26);
  endfunction : vec_base

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction : merge
endpackage : timer_pkg

/* verilog/irq_if.sv */
// Request lines and arbitration result shared between core and arbiter
`timescale 1ns/1ns
interface irq_if;
  import timer_pkg::*;
  logic [NVEC-1:0] req;
  logic [NVEC-1:0] dtc_ok;
  logic            hit;
  logic [4:0]      id;
  logic            dtc_go;
  modport src (output req, output dtc_ok, input hit, input id, input dtc_go);
  modport arb (input req, input dtc_ok, output hit, output id, output dtc_go);
endinterface : irq_if

/* verilog/irq_prio.sv */
// Fixed-priority pick of the pending request line
`timescale 1ns/1ns
module irq_prio
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  irq_if.arb       p
);
  import timer_pkg::*;
  logic       hit_q;
  logic [4:0] id_q;
  logic       go_q;
  logic [4:0] win;

  // Lowest index wins, so the loop runs downward
  always_comb
  begin
    win = 5'h1F;
    for (int i = NVEC - 1; i >= 0; i--)
    begin
      if (p.req[i])
        win = 5'(i);
    end
  end

  // Registered result keeps data outputs glitch free
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hit_q <= 1'b0;
      id_q  <= 5'h00;
      go_q  <= 1'b0;
    end
    else
    begin
      hit_q <= |p.req;
      id_q  <= win;
      go_q  <= (|p.req) && p.dtc_ok[win];
    end
  end

  assign p.hit    = hit_q;
  assign p.id     = id_q;
  assign p.dtc_go = go_q;

  property p_prio;
    @(posedge core_clk) disable iff (rst)
    (p.req != '0) |=> (p.hit && (($past(p.req) & ((32'h1 << p.id) - 32'h1)) == '0));
  endproperty
  a_prio : assert property (p_prio) else $error("lower request line won arbitration");
endmodule : irq_prio

/* verilog/timer_irq_core.sv */
// Seven-channel 16-bit timer: counters, flags, requests and access contention
`timescale 1ns/1ns
module timer_irq_core
  import timer_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [timer_pkg::AW-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [2*timer_pkg::NCH-1:0] cap_in,
  input  wire logic                     phase_a,
  input  wire logic                     phase_b,
  output logic      [2*timer_pkg::NCH-1:0] match_out,
  output logic      [timer_pkg::NVEC-1:0]  irq_o,
  output logic                          irq_valid,
  output logic      [4:0]               irq_id,
  output logic                          dtc_start
);
  import timer_pkg::*;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       acc;
  logic       wr;
  logic [2:0] ach;
  logic [3:0] aix;
  logic       a_ok;
  logic [31:0] rd_v;
  logic [31:0] rdata_q;

  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  assign ach = paddr[8:6];
  assign aix = paddr[5:2];

  function automatic logic wr_to(int c, logic [3:0] ix);
    return wr && (ach == 3'(c)) && (aix == ix);
  endfunction : wr_to

  // Channel 0 window holds the global registers
  always_comb
  begin
    a_ok = 1'b0;
    if (paddr[AW-1:9] != '0 || paddr[1:0] != 2'b00)
      a_ok = 1'b0;
    else if (ach == 3'd0)
      a_ok = (aix <= IX_ARB);
    else if (aix <= IX_IEN)
      a_ok = 1'b1;
    else if (aix >= IX_DR)
      a_ok = (32'(aix - IX_DR) < 32'(n_dr(int'(ach))));
    else
      a_ok = (32'(aix - IX_GR) < 32'(n_gr(int'(ach))));
  end

  assign pready  = 1'b1;
  assign pslverr = acc & ~a_ok;
  assign prdata  = rdata_q;

  // ****************************************************************
  // Channel state
  // ****************************************************************
  logic [15:0] cnt_q  [1:NCH];
  logic [8:0]  ctrl_q [1:NCH];
  logic [23:0] ien_q  [1:NCH];
  logic [15:0] gr_q   [1:NCH][0:3];
  logic [15:0] dr_q   [1:NCH][0:3];
  logic [3:0]  gf_q   [1:NCH];
  logic [3:0]  df_q   [1:NCH];
  logic [NCH:1] wf_q;
  logic [NCH:1] moved_q;
  logic [1:0]  cap1_q [1:NCH];
  logic [1:0]  mg1_q  [1:NCH];
  logic [NCH:1] sync_q;
  logic [6:0]  pre_q;
  logic        qa_q;
  logic        qb_q;
  logic [NVEC-1:0] irq_q;

  logic [15:0] cnt_d [1:NCH];
  logic [15:0] wval  [0:NCH];
  logic [3:0]  mg    [1:NCH];
  logic [3:0]  md    [1:NCH];
  logic [NCH:1] ovf_ev;
  logic [NCH:1] clr_ev;
  logic [NCH:1] tk;
  logic [1:0]  capm  [1:NCH];
  logic        q_chg;
  logic        q_up;
  logic        sync_wr;

  function automatic logic tick_of(logic [2:0] ps, logic [6:0] pre);
    logic [6:0] m;
    m = ~(7'h7F << ps);
    return &(pre | ~m);
  endfunction : tick_of

  // Direct mode compares only after the counter moved, so a rewrite alone never hits
  function automatic logic cmp(logic direct, logic t, logic mv, logic [15:0] c, logic [15:0] r);
    if (direct)
      return mv && (c == r);
    return t && (16'(c + 16'h1) == r) && (r != CNT_ZERO);
  endfunction : cmp

  assign q_chg   = (phase_a != qa_q) | (phase_b != qb_q);
  assign q_up    = qa_q ^ phase_b;
  assign sync_wr = wr_to(int'(ach), IX_CNT) && (ach != 3'd0) && sync_q[ach];

  // ****************************************************************
  // Per-channel next-state logic
  // ****************************************************************
  always_comb
  begin
    wval[0] = 16'h0000;
    for (int c = 1; c <= NCH; c++)
    begin
      logic ph;
      logic st;
      logic up;
      logic [15:0] sv;
      logic [15:0] base;
      ph      = (c == NCH) && ctrl_q[c][CF_PH];
      tk[c]   = tick_of(ctrl_q[c][CF_PS +: 3], pre_q);
      st      = ctrl_q[c][CF_RUN] && (ph ? q_chg : tk[c]);
      up      = ph ? q_up : 1'b1;
      capm[c] = ctrl_q[c][CF_CAP +: 2];
      sv      = up ? 16'(cnt_q[c] + 16'h1) : 16'(cnt_q[c] - 16'h1);
      base    = st ? sv : cnt_q[c];
      // Write lands in the final bus phase, so unwritten bytes still step
      wval[c] = 16'(merge({16'h0000, base}, pwdata, wr_to(c, IX_CNT) ? pstrb : 4'h0));
      for (int k = 0; k < 4; k++)
      begin
        mg[c][k] = (k < n_gr(c)) && !(k < 2 && capm[c][k]) && !wr_to(c, 4'(IX_GR + k))
                 && cmp(ph || ctrl_q[c][CF_PS +: 3] == 3'd0, tk[c], moved_q[c], cnt_q[c], gr_q[c][k]);
        md[c][k] = (k < n_dr(c)) && !wr_to(c, 4'(IX_DR + k))
                 && cmp(ph || ctrl_q[c][CF_PS +: 3] == 3'd0, tk[c], moved_q[c], cnt_q[c], dr_q[c][k]);
      end
      case (clr_t'(ctrl_q[c][CF_CLR +: 2]))
        CLR_GR1: clr_ev[c] = mg[c][0];
        CLR_GR2: clr_ev[c] = mg[c][1];
        CLR_CAP: clr_ev[c] = cap_in[2*(c-1)] && capm[c][0];
        default: clr_ev[c] = 1'b0;
      endcase
      ovf_ev[c] = st && !clr_ev[c] && (up ? cnt_q[c] == CNT_MAX : cnt_q[c] == CNT_ZERO);
    end
    for (int c = 1; c <= NCH; c++)
    begin
      if (clr_ev[c])
        cnt_d[c] = CNT_ZERO;
      else if (sync_wr && sync_q[c])
        cnt_d[c] = wval[ach];
      else if (wr_to(c, IX_CNT))
        cnt_d[c] = wval[c];
      else
        cnt_d[c] = wval[c];
    end
  end

  // Counter step value reuses the merge with no lanes when no write is present
  // ****************************************************************
  // Counters, prescaler and phase inputs
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pre_q   <= 7'h00;
      qa_q    <= 1'b0;
      qb_q    <= 1'b0;
      moved_q <= '0;
      for (int c = 1; c <= NCH; c++)
        cnt_q[c] <= CNT_ZERO;
    end
    else
    begin
      pre_q <= 7'(pre_q + 7'h01);
      qa_q  <= phase_a;
      qb_q  <= phase_b;
      for (int c = 1; c <= NCH; c++)
      begin
        cnt_q[c]   <= cnt_d[c];
        moved_q[c] <= (cnt_d[c] != cnt_q[c]);
      end
    end
  end

  // ****************************************************************
  // Control and compare registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync_q <= '0;
      for (int c = 1; c <= NCH; c++)
      begin
        ctrl_q[c] <= 9'h000;
        ien_q[c]  <= 24'h000000;
        cap1_q[c] <= 2'b00;
        for (int k = 0; k < 4; k++)
        begin
          gr_q[c][k] <= 16'h0000;
          dr_q[c][k] <= 16'h0000;
        end
      end
    end
    else
    begin
      if (wr_to(0, IX_SYNC))
        sync_q <= NCH'(merge({24'h0, sync_q, 1'b0}, pwdata, pstrb) >> 1);
      for (int c = 1; c <= NCH; c++)
      begin
        if (wr_to(c, IX_CTRL))
          ctrl_q[c] <= 9'(merge({23'h0, ctrl_q[c]}, pwdata, pstrb));
        if (wr_to(c, IX_IEN))
          ien_q[c] <= 24'(merge({8'h0, ien_q[c]}, pwdata, pstrb));
        for (int k = 0; k < 4; k++)
        begin
          // Capture beats a register write in the same cycle
          if (k < 2 && capm[c][k] && cap_in[2*(c-1)+k])
            gr_q[c][k] <= cnt_q[c];
          else if (k < n_gr(c) && wr_to(c, 4'(IX_GR + k)))
            gr_q[c][k] <= 16'(merge({16'h0, gr_q[c][k]}, pwdata, pstrb));
          if (k < n_dr(c) && wr_to(c, 4'(IX_DR + k)))
            dr_q[c][k] <= 16'(merge({16'h0, dr_q[c][k]}, pwdata, pstrb));
        end
        cap1_q[c] <= cap_in[2*(c-1) +: 2] & capm[c];
      end
    end
  end

  // ****************************************************************
  // Flags: write one to clear, a same-cycle set wins
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wf_q <= '0;
      for (int c = 1; c <= NCH; c++)
      begin
        gf_q[c]  <= 4'h0;
        df_q[c]  <= 4'h0;
        mg1_q[c] <= 2'b00;
      end
    end
    else
    begin
      for (int c = 1; c <= NCH; c++)
      begin
        logic wc;
        wc = wr_to(c, IX_STAT);
        gf_q[c]  <= (gf_q[c] & ~(wc ? pwdata[3:0] : 4'h0)) | mg[c] | {2'b00, cap1_q[c]};
        df_q[c]  <= (df_q[c] & ~(wc ? pwdata[ST_DR +: 4] : 4'h0)) | md[c];
        wf_q[c]  <= (wf_q[c] & ~(wc && pwdata[ST_WR])) | ovf_ev[c];
        mg1_q[c] <= mg[c][1:0];
      end
    end
  end

  // ****************************************************************
  // Request lines, match outputs and read data
  // ****************************************************************
  irq_if ifc ();
  logic [NVEC-1:0] req_v;
  logic [NVEC-1:0] dtc_v;

  // Pairs share one line; wrap lines never carry a transfer enable
  always_comb
  begin
    req_v = '0;
    dtc_v = '0;
    for (int c = 1; c <= NCH; c++)
    begin
      logic [3:0]  gq;
      logic [3:0]  dq;
      int b;
      int w;
      gq = gf_q[c] & ien_q[c][3:0];
      dq = df_q[c] & ien_q[c][ST_DR +: 4];
      b  = vec_base(c);
      w  = b + ((n_dr(c) > 0) ? 3 : 2);
      req_v[b]   = gq[0];
      req_v[b+1] = gq[1];
      dtc_v[b]   = ien_q[c][IE_DTC];
      dtc_v[b+1] = ien_q[c][IE_DTC+1];
      req_v[w]   = wf_q[c] & ien_q[c][ST_WR];
      if (n_dr(c) > 0)
      begin
        req_v[b+2] = dq[0] | dq[1];
        dtc_v[b+2] = (dq[0] & ien_q[c][IE_DTC+4]) | (dq[1] & ien_q[c][IE_DTC+5]);
      end
      if (c == 1)
      begin
        req_v[b+4] = gq[2];
        req_v[b+5] = gq[3];
        req_v[b+6] = dq[2] | dq[3];
        dtc_v[b+4] = ien_q[c][IE_DTC+2];
        dtc_v[b+5] = ien_q[c][IE_DTC+3];
        dtc_v[b+6] = (dq[2] & ien_q[c][IE_DTC+6]) | (dq[3] & ien_q[c][IE_DTC+7]);
      end
    end
  end

  // Read mux: old register contents, so a capture in the same edge is not seen
  always_comb
  begin
    rd_v = 32'h0;
    if (!a_ok || ach == 3'd0)
      rd_v = (a_ok && aix == IX_SYNC) ? {24'h0, sync_q, 1'b0}
           : (a_ok ? {26'h0, ifc.hit, ifc.id} : 32'h0);
    else if (aix == IX_CNT)
      rd_v = {16'h0, cnt_q[ach]};
    else if (aix == IX_CTRL)
      rd_v = {23'h0, ctrl_q[ach]};
    else if (aix == IX_STAT)
      rd_v = {23'h0, wf_q[ach], df_q[ach], gf_q[ach]};
    else if (aix == IX_IEN)
      rd_v = {8'h0, ien_q[ach]};
    else if (aix >= IX_DR)
      rd_v = {16'h0, dr_q[ach][aix[1:0]]};
    else
      rd_v = {16'h0, gr_q[ach][aix[1:0]]};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata_q   <= 32'h0;
      irq_q     <= '0;
      match_out <= '0;
    end
    else
    begin
      if (psel && !penable)
        rdata_q <= rd_v;
      irq_q <= req_v;
      for (int c = 1; c <= NCH; c++)
        match_out[2*(c-1) +: 2] <= mg1_q[c];
    end
  end

  assign ifc.req    = irq_q;
  assign ifc.dtc_ok = dtc_v;
  assign irq_o      = irq_q;
  assign irq_valid  = ifc.hit;
  assign irq_id     = ifc.id;
  assign dtc_start  = ifc.dtc_go;

  irq_prio u_prio (
    .core_clk (core_clk),
    .rst      (rst),
    .p        (ifc.arb)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_flag;
    @(posedge core_clk) disable iff (rst) mg[2][0] |=> gf_q[2][0];
  endproperty
  a_flag : assert property (p_flag) else $error("match flag late");

  property p_cmp_irq;
    @(posedge core_clk) disable iff (rst) (mg[2][0] && ien_q[2][0]) |-> ##2 (irq_o[7] && match_out[2]);
  endproperty
  a_cmp_irq : assert property (p_cmp_irq) else $error("compare request not at two cycles");

  property p_cap;
    @(posedge core_clk) disable iff (rst)
    (cap_in[10] && capm[6][0] && ien_q[6][0]) |=> (gr_q[6][0] == $past(cnt_q[6])) ##1 gf_q[6][0] ##1 irq_o[23];
  endproperty
  a_cap : assert property (p_cap) else $error("capture sequence wrong");

  property p_wrap;
    @(posedge core_clk) disable iff (rst) (ovf_ev[3] && ien_q[3][ST_WR]) |=> wf_q[3] ##1 irq_o[14];
  endproperty
  a_wrap : assert property (p_wrap) else $error("wrap request timing wrong");

  property p_down;
    @(posedge core_clk) disable iff (rst)
    (ctrl_q[7][CF_PH] && $past(cnt_q[7]) == CNT_ZERO && cnt_q[7] == CNT_MAX && !$past(sync_wr)
     && !$past(wr_to(7, IX_CNT))) |-> wf_q[7];
  endproperty
  a_down : assert property (p_down) else $error("downward wrap missed");

  property p_clr;
    @(posedge core_clk) disable iff (rst) (clr_ev[6] && wr_to(6, IX_CNT)) |=> (cnt_q[6] == CNT_ZERO);
  endproperty
  a_clr : assert property (p_clr) else $error("write beat clear");

  property p_wrinc;
    @(posedge core_clk) disable iff (rst)
    (wr_to(7, IX_CNT) && pstrb[1:0] == 2'b11 && !clr_ev[7] && !sync_wr) |=> (cnt_q[7] == $past(pwdata[15:0]));
  endproperty
  a_wrinc : assert property (p_wrinc) else $error("write lost to increment");

  property p_nomatch;
    @(posedge core_clk) disable iff (rst) wr_to(4, IX_GR) |-> !mg[4][0];
  endproperty
  a_nomatch : assert property (p_nomatch) else $error("match during rewrite");

  property p_zero;
    @(posedge core_clk) disable iff (rst)
    (ctrl_q[5][CF_PS +: 3] != 3'd0 && gr_q[5][0] == CNT_ZERO) |-> !mg[5][0];
  endproperty
  a_zero : assert property (p_zero) else $error("prescaled zero matched");

  property p_sync;
    @(posedge core_clk) disable iff (rst)
    (sync_wr && sync_q[2] && sync_q[3] && !clr_ev[2] && !clr_ev[3]) |=> (cnt_q[2] == cnt_q[3]);
  endproperty
  a_sync : assert property (p_sync) else $error("synchronized counters differ");
endmodule : timer_irq_core

/* verif/dtc_model.sv */
// Transfer controller model that watches start requests
`timescale 1ns/1ns
module dtc_model
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        dtc_start,
  input  wire logic [4:0]  irq_id,
  output logic      [15:0] starts_q,
  output logic             bad_q
);
  // Count starts; a wrap line must never start one
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      starts_q <= 16'h0000;
      bad_q    <= 1'b0;
    end
    else if (dtc_start)
    begin
      starts_q <= starts_q + 16'h0001;
      if (irq_id inside {5'h03, 5'h0A, 5'h0E, 5'h12, 5'h16, 5'h19, 5'h1C})
        bad_q <= 1'b1;
    end
  end
endmodule : dtc_model

/* verif/timer_irq_timing_contention_tb.sv */
// Self-checking bench of timer flags, requests and access contention
`timescale 1ns/1ns
module timer_irq_timing_contention_tb;
  import timer_pkg::*;
  logic            core_clk = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [AW-1:0]   paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic [3:0]      pstrb = 4'h0;
  logic [13:0]     cap_in = 14'h0;
  logic            phase_a = 1'b0;
  logic            phase_b = 1'b0;
  logic            back_to_back = 1'b0;
  logic [31:0]     prdata;
  logic            pready, pslverr, irq_valid, dtc_start;
  logic [13:0]     match_out;
  logic [NVEC-1:0] irq_o;
  logic [4:0]      irq_id;
  logic [15:0]     starts;
  logic            bad;
  int              mismatches = 0;
  int              checked = 0;

  always #25 core_clk = ~core_clk;

  timer_irq_core u_timer_irq_core (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .phase_a(phase_a), .phase_b(phase_b), .match_out(match_out),
    .irq_o(irq_o), .irq_valid(irq_valid), .irq_id(irq_id), .dtc_start(dtc_start));
  dtc_model u_dtc_model (.core_clk(core_clk), .rst(rst), .dtc_start(dtc_start), .irq_id(irq_id),
    .starts_q(starts), .bad_q(bad));

  // ****************************************************
  // Bus cycles and comparison
  // ****************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Keeping psel up (rel low) lets the next setup follow at once
  task automatic apb(input logic w, input int ch, input logic [3:0] ix, input logic [31:0] wd,
                     input logic [3:0] sb, input logic rel, output logic [31:0] rd, output logic err);
    // Every request starts just after a rising edge; a held psel means setup follows at once
    if (!back_to_back)
      @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {3'h0, 3'(ch), ix, 2'h0};
    pwdata <= wd;
    pstrb  <= sb;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (rel)
      psel <= 1'b0;
    back_to_back = !rel;
  endtask : apb

  task automatic wr(input int ch, input logic [3:0] ix, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ch, ix, d, 4'hF, 1'b1, r, e);
  endtask : wr

  task automatic rdr(input int ch, input logic [3:0] ix, output logic [31:0] r);
    logic e;
    apb(1'b0, ch, ix, 32'h0, 4'h0, 1'b1, r, e);
  endtask : rdr

  // Waits for a match pulse, then measures the distance to the next one
  task automatic period(input int b, input int ln, input int exp);
    int n;
    n = 0;
    while (match_out[b] !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (ln >= 0)
      chk("request with match", 32'h1, {31'h0, irq_o[ln]});
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (match_out[b] !== 1'b1 && n < 200);
    chk("match period", exp, n);
  endtask : period

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic test_compare();
    logic [31:0] st;
    wr(2, IX_GR, 32'h5);
    wr(2, IX_IEN, 32'h0001_0001);
    wr(2, IX_CTRL, 32'h11);
    period(2, 7, 6);
    @(negedge core_clk);
    chk("winner", 32'h7, {27'h0, irq_id});
    chk("request pending", 32'h1, {31'h0, irq_valid});
    chk("transfer start", 32'h1, {31'h0, dtc_start});
    wr(2, IX_CTRL, 32'h0);
    rdr(2, IX_STAT, st);
    chk("compare flag", 32'h1, {31'h0, st[0]});
    $display("test compare done");
  endtask : test_compare

  task automatic test_wrap();
    logic [31:0] st;
    int          n;
    wr(3, IX_CNT, 32'hFFFD);
    wr(3, IX_IEN, 32'h100);
    wr(3, IX_CTRL, 32'h1);
    n = 0;
    while (irq_o[14] !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("wrap request", 32'h1, {31'h0, irq_o[14]});
    rdr(3, IX_STAT, st);
    chk("wrap flag", 32'h1, {31'h0, st[8]});
    chk("higher line wins", 32'h7, {27'h0, irq_id});
    wr(2, IX_STAT, 32'h1);
    repeat (3) @(negedge core_clk);
    chk("cleared request", 32'h0, {31'h0, irq_o[7]});
    chk("wrap wins", 32'hE, {27'h0, irq_id});
    chk("no wrap transfer", 32'h0, {31'h0, dtc_start});
    $display("test wrap done");
  endtask : test_wrap

  task automatic test_capture();
    logic [31:0] r;
    wr(6, IX_IEN, 32'h1);
    wr(6, IX_CTRL, 32'h41);
    @(posedge core_clk);
    cap_in[10] <= 1'b1;
    @(posedge core_clk);
    cap_in[10] <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("capture request early", 32'h0, {31'h0, irq_o[23]});
    @(negedge core_clk);
    chk("capture request", 32'h1, {31'h0, irq_o[23]});
    // Capture clear held across the whole write: counter restarts from zero, one step before the read
    wr(6, IX_CTRL, 32'h71);
    cap_in[10] <= 1'b1;
    wr(6, IX_CNT, 32'h77);
    cap_in[10] <= 1'b0;
    rdr(6, IX_CNT, r);
    chk("clear beats write", 32'h1, r);
    $display("test capture done");
  endtask : test_capture

  // One rise of phase_a with phase_b low counts down from zero
  task automatic test_phase();
    logic [31:0] r;
    wr(7, IX_IEN, 32'h100);
    wr(7, IX_CTRL, 32'h101);
    phase_a <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("downward wrap request", 32'h1, {31'h0, irq_o[28]});
    rdr(7, IX_CNT, r);
    chk("down count", 32'hFFFF, r);
    $display("test phase done");
  endtask : test_phase

  task automatic test_prescale();
    int hits;
    hits = 0;
    wr(4, IX_GR, 32'h3);
    wr(4, IX_CTRL, 32'h13);
    period(6, -1, 6);
    wr(5, IX_CNT, 32'hFFFF);
    wr(5, IX_CTRL, 32'h13);
    repeat (40)
    begin
      @(negedge core_clk);
      hits += int'(match_out[8] === 1'b1);
    end
    chk("zero value match", 32'h0, hits);
    $display("test prescale done");
  endtask : test_prescale

  task automatic test_access();
    logic [31:0] r;
    logic        e;
    wr(7, IX_CTRL, 32'h1);
    apb(1'b1, 7, IX_CNT, 32'h1234, 4'hF, 1'b0, r, e);
    apb(1'b0, 7, IX_CNT, 32'h0, 4'h0, 1'b1, r, e);
    chk("written count", 32'h1234, r);
    wr(3, IX_CTRL, 32'h0);
    wr(0, IX_SYNC, 32'hC);
    wr(2, IX_CNT, 32'hAB);
    apb(1'b1, 2, IX_CNT, 32'h5500, 4'h2, 1'b1, r, e);
    rdr(3, IX_CNT, r);
    chk("synced count", 32'h55AB, r);
    apb(1'b0, 6, IX_GR + 4'h2, 32'h0, 4'h0, 1'b1, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("test access done");
  endtask : test_access

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Whole run is well under a thousand cycles; this cuts a hang short
  initial
  begin
    #(50 * 8000);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("requests after reset", 32'h0, {3'h0, irq_o});
    test_compare();
    test_wrap();
    test_capture();
    test_prescale();
    test_phase();
    test_access();
    chk("transfer on wrap line", 32'h0, {31'h0, bad});
    chk("transfers started", 32'h1, {31'h0, starts != 16'h0000});
    report_and_stop();
  end
endmodule : timer_irq_timing_contention_tb
